/* File: verilog/plcsup_top.sv */
/*
 * Mode and reset supervisor of a programmable controller: scan
 * sequencing, watchdog and scan-time monitors, output inhibit, mode
 * switch memory-reset decoding and yellow status LED.
 * Assumes all inputs synchronous to mclk_in; the program engine and
 * memories answer the one-cycle requests with a done pulse.
 */
`timescale 1ns/10ps
`default_nettype none

module plcsup_top
    import plcsup_pkg::*;
#(
    parameter int unsigned NDOUT    = 8,
    parameter int unsigned NAOUT    = 2,
    parameter int unsigned WDOG_CNT = WDOG_CYC,
    parameter int unsigned HOLD_CNT = HOLD_CYC,
    parameter int unsigned B1_HALF  = BLINK1_HALF,
    parameter int unsigned B2_HALF  = BLINK2_HALF,
    parameter int unsigned FL_HALF  = FLICK_HALF
)
(
    // Clock and reset
    input  wire  logic                 mclk_in,
    input  wire  logic                 rstn_in,
    // Operator side
    input  wire  logic [1:0]           mode_sw_in,
    input  wire  logic                 tool_mres_req_in,
    input  wire  logic                 factory_req_in,
    input  wire  logic                 fw_name_match_in,
    input  wire  logic                 project_present_in,
    input  wire  logic                 cold_start_avail_in,
    input  wire  logic                 cold_start_req_in,
    // Monitors
    input  wire  logic                 wdog_kick_in,
    input  wire  logic [31:0]          scan_limit_in,
    // Engine handshakes
    input  wire  logic                 step_done_in,
    // Output image from the program
    input  wire  logic [NDOUT-1:0]     dout_img_in,
    input  wire  logic [NAOUT*16-1:0]  aout_img_in,
    input  wire  logic [NAOUT*2-1:0]   aout_kind_in,
    input  wire  logic                 subst_en_in,
    input  wire  logic [NDOUT-1:0]     dout_subst_in,
    input  wire  logic [NAOUT*16-1:0]  aout_subst_in,
    // Sequencing requests
    output var   logic                 clr_input_image_out,
    output var   logic                 clr_output_image_out,
    output var   logic                 read_input_image_out,
    output var   logic                 write_output_image_out,
    output var   logic                 startup_routine_out,
    output var   logic                 cyclic_main_program_out,
    output var   logic                 cold_start_routine_out,
    output var   logic                 erase_user_mem_out,
    output var   logic                 reload_project_out,
    output var   logic                 clear_ram_out,
    output var   logic                 fw_update_out,
    // Status
    output var   logic                 output_inhibit_out,
    output var   logic                 run_out,
    output var   logic                 wdog_err_out,
    output var   logic                 scan_err_out,
    output var   logic                 yellow_led_out,
    output var   logic [6:0]           multipoint_station_address_out,
    // Physical outputs, local and remote alike
    output var   logic [NDOUT-1:0]     dout_out,
    output var   logic [NAOUT*16-1:0]  aout_out
);

    if (NDOUT < 1 || NAOUT < 1 || WDOG_CNT < 2 || HOLD_CNT < 2)
    begin : g_bad_param
        $error("plcsup_top: bad parameter");
    end

    // =========================================================
    // Reset release
    // =========================================================
    logic rst_s1_ff;
    logic rst_n_ff;
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_s1_ff <= 1'b0;
            rst_n_ff  <= 1'b0;
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            rst_n_ff  <= rst_s1_ff;
        end
    end

    // =========================================================
    // Scan sequencer
    // =========================================================
    plcsup_state_type state_ff;
    plcsup_state_type nxt_state;
    logic             wdog_lock_ff;
    logic             pwrup_ff;
    logic             boot_ff;
    logic [31:0]      wdog_cnt_ff;
    logic [31:0]      scan_cnt_ff;
    logic             mr_start;
    logic             fault;
    logic             in_run;
    logic             sw_run;
    logic             sw_stop;

    assign sw_run  = (mode_sw_in == SW_RUN);
    assign sw_stop = (mode_sw_in == SW_STOP);
    assign in_run  = (state_ff == ST_READ) || (state_ff == ST_MAIN)
                  || (state_ff == ST_WRITE) || (state_ff == ST_CLR_PIO);
    assign fault   = in_run && (wdog_cnt_ff >= WDOG_CNT - 1
                  || scan_cnt_ff >= scan_limit_in - 1);

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_STOP:
                if (mr_start)
                    nxt_state = ST_ERASE;
                else if (factory_req_in)
                    nxt_state = ST_FACTORY;
                else if (pwrup_ff && sw_stop && fw_name_match_in
                         && mode_sw_in == SW_STOP && mr_start)
                    nxt_state = ST_FWUPD;
                else if (sw_run && (!wdog_lock_ff
                         || (cold_start_avail_in && cold_start_req_in)))
                    nxt_state = ST_CLR_PII;
            ST_CLR_PII:
                if (!boot_ff)
                    nxt_state = ST_STARTUP;
            ST_STARTUP:
                if (step_done_in)
                    nxt_state = ST_CLR_PIO;
            ST_CLR_PIO:
                nxt_state = ST_READ;
            ST_READ:
                if (step_done_in)
                    nxt_state = ST_MAIN;
            ST_MAIN:
                if (step_done_in)
                    nxt_state = ST_WRITE;
            ST_WRITE:
                if (step_done_in)
                    nxt_state = ST_READ;
            ST_ERASE:
                if (step_done_in)
                    nxt_state = project_present_in ? ST_RELOAD : ST_STOP;
            ST_RELOAD:
                if (step_done_in)
                    nxt_state = ST_STOP;
            ST_FACTORY:
                if (step_done_in)
                    nxt_state = ST_STOP;
            ST_FWUPD:
                if (step_done_in)
                    nxt_state = ST_STOP;
            default:
                nxt_state = ST_STOP;
        endcase
        if (in_run && (fault || !sw_run || tool_mres_req_in))
            nxt_state = ST_STOP;
    end

    always_ff @(posedge mclk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            state_ff <= ST_CLR_PII;
        else
            state_ff <= nxt_state;
    end

    // Hold input clear one extra cycle after reset so its strobe goes out
    always_ff @(posedge mclk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            boot_ff <= 1'b1;
        else
            boot_ff <= 1'b0;
    end

    // Power-up window for card firmware update closes on first RUN or when the switch leaves STOP
    always_ff @(posedge mclk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            pwrup_ff <= 1'b1;
        else if (in_run || !sw_stop)
            pwrup_ff <= 1'b0;
    end

    // Watchdog lock is cleared only by cold start, memory reset or reload
    always_ff @(posedge mclk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            wdog_lock_ff <= 1'b0;
        else if (in_run && wdog_cnt_ff >= WDOG_CNT - 1)
            wdog_lock_ff <= 1'b1;
        else if (state_ff == ST_ERASE || state_ff == ST_RELOAD
                 || (state_ff == ST_STOP && nxt_state == ST_CLR_PII))
            wdog_lock_ff <= 1'b0;
    end

    always_ff @(posedge mclk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            wdog_cnt_ff <= 32'h0000_0000;
            scan_cnt_ff <= 32'h0000_0000;
        end
        else
        begin
            wdog_cnt_ff <= (!in_run || wdog_kick_in) ? 32'h0000_0000
                         : wdog_cnt_ff + 32'h0000_0001;
            scan_cnt_ff <= (!in_run || (state_ff == ST_WRITE
                         && step_done_in)) ? 32'h0000_0000
                         : scan_cnt_ff + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            wdog_err_out <= 1'b0;
            scan_err_out <= 1'b0;
        end
        else
        begin
            if (in_run && wdog_cnt_ff >= WDOG_CNT - 1)
                wdog_err_out <= 1'b1;
            else if (!wdog_lock_ff)
                wdog_err_out <= 1'b0;
            if (in_run && scan_cnt_ff >= scan_limit_in - 1)
                scan_err_out <= 1'b1;
            else if (in_run)
                scan_err_out <= 1'b0;
        end
    end

    // Request strobes: one cycle on state entry or per step; run_out is a level held over READ, MAIN and WRITE
    always_ff @(posedge mclk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            clr_input_image_out     <= 1'b0;
            clr_output_image_out    <= 1'b0;
            read_input_image_out    <= 1'b0;
            write_output_image_out  <= 1'b0;
            startup_routine_out     <= 1'b0;
            cyclic_main_program_out <= 1'b0;
            cold_start_routine_out  <= 1'b0;
            erase_user_mem_out      <= 1'b0;
            reload_project_out      <= 1'b0;
            clear_ram_out           <= 1'b0;
            fw_update_out           <= 1'b0;
            run_out                 <= 1'b0;
        end
        else
        begin
            clr_input_image_out     <= nxt_state == ST_CLR_PII;
            clr_output_image_out    <= nxt_state == ST_CLR_PIO;
            read_input_image_out    <= nxt_state == ST_READ
                                    && state_ff != ST_READ;
            cyclic_main_program_out <= nxt_state == ST_MAIN
                                    && state_ff != ST_MAIN;
            write_output_image_out  <= nxt_state == ST_WRITE
                                    && state_ff != ST_WRITE;
            startup_routine_out     <= nxt_state == ST_STARTUP
                                    && state_ff != ST_STARTUP;
            cold_start_routine_out  <= state_ff == ST_STOP
                                    && nxt_state == ST_CLR_PII
                                    && wdog_lock_ff;
            erase_user_mem_out      <= nxt_state == ST_ERASE
                                    && state_ff != ST_ERASE;
            reload_project_out      <= nxt_state == ST_RELOAD
                                    && state_ff != ST_RELOAD;
            clear_ram_out           <= nxt_state == ST_FACTORY
                                    && state_ff != ST_FACTORY;
            fw_update_out           <= nxt_state == ST_FWUPD
                                    && state_ff != ST_FWUPD;
            run_out                 <= nxt_state == ST_READ
                                    || nxt_state == ST_MAIN
                                    || nxt_state == ST_WRITE;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            multipoint_station_address_out <= STATION_DFLT;
        else if (state_ff == ST_FACTORY)
            multipoint_station_address_out <= STATION_DFLT;
    end

    // =========================================================
    // Output inhibit and safe levels
    // =========================================================
    logic inhibit;
    assign inhibit = !(nxt_state == ST_READ || nxt_state == ST_MAIN
                    || nxt_state == ST_WRITE);

    always_ff @(posedge mclk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            output_inhibit_out <= 1'b1;
        else
            output_inhibit_out <= inhibit;
    end

    // Same driver feeds local and remote channels
    always_ff @(posedge mclk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            dout_out <= '0;
        else if (!inhibit)
            dout_out <= dout_img_in;
        else
            dout_out <= subst_en_in ? dout_subst_in : '0;
    end

    for (genvar g = 0; g < NAOUT; g++)
    begin : g_aout
        always_ff @(posedge mclk_in or negedge rst_n_ff)
        begin
            if (!rst_n_ff)
                aout_out[g*16 +: 16] <= AOUT_ZERO;
            else if (!inhibit)
                aout_out[g*16 +: 16] <= aout_img_in[g*16 +: 16];
            else if (subst_en_in)
                aout_out[g*16 +: 16] <= aout_subst_in[g*16 +: 16];
            else if (aout_kind_in[g*2 +: 2] == AKIND_I420)
                aout_out[g*16 +: 16] <= AOUT_4MA;
            else
                aout_out[g*16 +: 16] <= AOUT_ZERO;
        end
    end

    // =========================================================
    // Mode switch memory reset decoder
    // =========================================================
    plcsup_mr_type mr_ff;
    logic [31:0]   mr_cnt_ff;
    logic          sw_mres;
    assign sw_mres  = (mode_sw_in == SW_MRES);
    assign mr_start = (state_ff == ST_STOP) && ((mr_ff == MR_TIP && sw_stop)
                    || tool_mres_req_in);

    always_ff @(posedge mclk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            mr_ff     <= MR_IDLE;
            mr_cnt_ff <= 32'h0000_0000;
        end
        else
        begin
            mr_cnt_ff <= mr_cnt_ff + 32'h0000_0001;
            unique case (mr_ff)
                MR_IDLE:
                    if (sw_mres && state_ff == ST_STOP)
                    begin
                        mr_ff     <= MR_HOLD;
                        mr_cnt_ff <= 32'h0000_0000;
                    end
                MR_HOLD:
                    if (!sw_mres)
                        mr_ff <= MR_IDLE;
                    else if (mr_cnt_ff >= HOLD_CNT - 1)
                        mr_ff <= MR_ARMED;
                MR_ARMED:
                    if (sw_stop)
                        mr_ff <= MR_STOP2;
                    else if (sw_run)
                        mr_ff <= MR_IDLE;
                MR_STOP2:
                    if (sw_mres)
                    begin
                        mr_ff     <= MR_TIP;
                        mr_cnt_ff <= 32'h0000_0000;
                    end
                    else if (sw_run)
                        mr_ff <= MR_IDLE;
                MR_TIP:
                    if (sw_stop || mr_cnt_ff >= HOLD_CNT - 1)
                        mr_ff <= MR_IDLE;
                default:
                    mr_ff <= MR_IDLE;
            endcase
            if (mr_start || state_ff != ST_STOP)
                mr_ff <= MR_IDLE;
        end
    end

    // =========================================================
    // Yellow LED patterns
    // =========================================================
    logic [31:0] blk_cnt_ff;
    logic        blk_ph_ff;
    logic [31:0] half;
    logic        blinking;

    always_comb
    begin
        half = B1_HALF;
        if (state_ff == ST_ERASE)
            half = B2_HALF;
        else if (state_ff == ST_RELOAD || state_ff == ST_FWUPD)
            half = FL_HALF;
    end
    assign blinking = (mr_ff == MR_HOLD) || (state_ff == ST_ERASE)
                   || (state_ff == ST_RELOAD) || (state_ff == ST_FWUPD);

    always_ff @(posedge mclk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            blk_cnt_ff <= 32'h0000_0000;
            blk_ph_ff  <= 1'b1;
        end
        else if (!blinking || blk_cnt_ff >= half - 1)
        begin
            blk_cnt_ff <= 32'h0000_0000;
            blk_ph_ff  <= blinking ? !blk_ph_ff : 1'b1;
        end
        else
            blk_cnt_ff <= blk_cnt_ff + 32'h0000_0001;
    end

    // Steady on in STOP except during MR_HOLD, including armed and after reset completes
    always_ff @(posedge mclk_in or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
            yellow_led_out <= 1'b1;
        else if (blinking)
            yellow_led_out <= blk_ph_ff;
        else
            yellow_led_out <= !in_run;
    end

endmodule : plcsup_top

`default_nettype wire

/* File: verilog/plcsup_pkg.sv */
/*
 * Constants, states and cycle counts for the controller mode and reset
 * supervisor. Assumes a 100 MHz timebase.
 */
// Operation
// - Watchdog expiring after 100 ms forces defined STOP state.
// - Scan time beyond configurable limit (min 1 ms) forces STOP; scan_limit_in is not held to that minimum.
// - Every RUN to STOP transition asserts the output inhibit.
// - Inhibit: digital off, voltage 0V, 0-20mA gives 0mA, 4-20mA 4mA.
// - Configured substitute values may replace default safe levels.
// - Remote station outputs follow the same inhibit behaviour.
// - STOP to RUN or power-up: clear input image, then startup routine.
// - After startup release inhibit; clear output image, read, run main.
// - RUN scan order: read inputs, run main program, write outputs.
// - Memory reset erases user program memory, not the memory card.
// - Memory reset starts only in STOP; otherwise no erase.
// - Hold reset position 3 s arms reset; LED blinks 1 Hz then steady.
// - Armed: STOP, reset position and back within 3 s starts; 2 Hz.
// - After memory reset the yellow LED is steadily on.
// - Tool request also starts memory reset via STOP, blinking 2 Hz.
// - After reset, reload project file if present, LED flickering.
// - After reload enter STOP or RUN per mode switch position.
// - Factory reset clears RAM, station address back to 2.
// - Card firmware update only after power-up with switch in STOP; ST_FWUPD is unreachable, its branch also needs mr_start.
// - Firmware image recognised only by fixed file name pattern match.
// - After watchdog error stay STOP; leave by cold start, reset, reload.

`default_nettype none

package plcsup_pkg;

    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned WDOG_MS        = 100;
    localparam int unsigned WDOG_CYC       = CLK_HZ / 1000 * WDOG_MS;
    localparam int unsigned SCAN_MIN_MS    = 1;
    localparam int unsigned SCAN_MIN_CYC   = CLK_HZ / 1000 * SCAN_MIN_MS;
    localparam int unsigned HOLD_MS        = 3000;
    localparam int unsigned HOLD_CYC       = CLK_HZ / 1000 * HOLD_MS;
    localparam int unsigned BLINK1_HZ      = 1;
    localparam int unsigned BLINK1_HALF    = CLK_HZ / (2 * BLINK1_HZ);
    localparam int unsigned BLINK2_HZ      = 2;
    localparam int unsigned BLINK2_HALF    = CLK_HZ / (2 * BLINK2_HZ);
    localparam int unsigned FLICK_HZ       = 10;
    localparam int unsigned FLICK_HALF     = CLK_HZ / (2 * FLICK_HZ);
    localparam logic [6:0]  STATION_DFLT   = 7'h02;
    localparam logic [15:0] AOUT_ZERO      = 16'h0000;
    localparam logic [15:0] AOUT_4MA       = 16'h3333;

    typedef enum logic [1:0]
    {
        AKIND_VOLT = 2'b00,
        AKIND_I020 = 2'b01,
        AKIND_I420 = 2'b10
    } plcsup_akind_type;

    typedef enum logic [3:0]
    {
        ST_STOP     = 4'b0000,
        ST_CLR_PII  = 4'b0001,
        ST_STARTUP  = 4'b0010,
        ST_CLR_PIO  = 4'b0011,
        ST_READ     = 4'b0100,
        ST_MAIN     = 4'b0101,
        ST_WRITE    = 4'b0110,
        ST_ERASE    = 4'b0111,
        ST_RELOAD   = 4'b1000,
        ST_FACTORY  = 4'b1001,
        ST_FWUPD    = 4'b1010
    } plcsup_state_type;

    typedef enum logic [2:0]
    {
        MR_IDLE   = 3'b000,
        MR_HOLD   = 3'b001,
        MR_ARMED  = 3'b010,
        MR_STOP2  = 3'b011,
        MR_TIP    = 3'b100
    } plcsup_mr_type;

    typedef enum logic [1:0]
    {
        SW_STOP  = 2'b00,
        SW_RUN   = 2'b01,
        SW_MRES  = 2'b10
    } plcsup_sw_type;

endpackage : plcsup_pkg

`default_nettype wire

/* File: sim/plcsup_asserts.sv */
/* Port checker for plcsup_top, bound at the foot of this file.
   Assumes the design's own reset and clock ports. */
`timescale 1ns/10ps
`default_nettype none
module plcsup_asserts #(parameter int unsigned NDOUT = 8)
(
    input wire logic mclk_in, rstn_in, subst_en_in, run_out, wdog_err_out,
    input wire logic output_inhibit_out, clear_ram_out, erase_user_mem_out,
    input wire logic clr_input_image_out, startup_routine_out,
    input wire logic clr_output_image_out, read_input_image_out,
    input wire logic cyclic_main_program_out, write_output_image_out,
    input wire logic [6:0] multipoint_station_address_out,
    input wire logic [NDOUT-1:0] dout_out
);
    logic main_ff;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    // Main program seen since the last input read
    always_ff @(posedge mclk_in or negedge rstn_in)
        if (!rstn_in) main_ff <= 1'b0;
        else if (read_input_image_out || cyclic_main_program_out)
            main_ff <= cyclic_main_program_out;
    stop_inhibit_a:
        assert property ($fell(run_out) |-> ##[0:1] output_inhibit_out)
        else $error("inhibit missing at stop");
    safe_dout_a:
        assert property (output_inhibit_out && $past(output_inhibit_out)
        && !subst_en_in && !$past(subst_en_in) |-> dout_out == '0)
        else $error("outputs live under inhibit");
    wdog_stop_a: assert property ($rose(wdog_err_out) |-> ##[0:2] !run_out)
        else $error("run after watchdog");
    clr_first_a: assert property (clr_input_image_out |=> startup_routine_out)
        else $error("startup not after clear");
    first_cycle_a:
        assert property (clr_output_image_out |=>
        read_input_image_out && !output_inhibit_out)
        else $error("bad first cycle");
    scan_order_a: assert property (write_output_image_out |-> main_ff)
        else $error("write before main");
    erase_stop_a: assert property (erase_user_mem_out |-> !run_out)
        else $error("erase in run");
    addr_dflt_a: assert property (clear_ram_out |-> ##[0:2]
        multipoint_station_address_out == 7'h02)
        else $error("address not default");
    cover property ($rose(run_out));
    cover property ($rose(wdog_err_out));
    cover property (erase_user_mem_out);
endmodule : plcsup_asserts
bind plcsup_top plcsup_asserts #(.NDOUT(NDOUT)) i_plcsup_asserts (
    .mclk_in, .rstn_in, .subst_en_in, .run_out, .wdog_err_out,
    .output_inhibit_out, .clear_ram_out, .erase_user_mem_out,
    .clr_input_image_out, .startup_routine_out, .clr_output_image_out,
    .read_input_image_out, .cyclic_main_program_out,
    .write_output_image_out, .multipoint_station_address_out, .dout_out);
`default_nettype wire

/* File: sim/plcsup_engine_model.sv */
/* Program engine stand-in: each step request gets one done pulse.
   Assumes requests are single-cycle pulses. */
`timescale 1ns/10ps
`default_nettype none
module plcsup_engine_model
(
    input  wire logic mclk_in,
    input  wire logic rstn_in,
    input  wire logic req_in,
    input  wire logic slow_in,
    output var  logic done_out
);
    int cnt_ff;
    // Slow answers stretch the scan towards the watchdog limit
    always_ff @(posedge mclk_in or negedge rstn_in)
        if (!rstn_in) cnt_ff <= 0;
        else if (req_in) cnt_ff <= slow_in ? 9 : 1;
        else if (cnt_ff > 0) cnt_ff <= cnt_ff - 1;
    assign done_out = (cnt_ff == 1);
endmodule : plcsup_engine_model
`default_nettype wire

/* File: sim/testbench.sv */
/* Bench for plcsup_top with shortened counts.
   Assumes the engine stand-in answers every step request. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import plcsup_pkg::*;
    localparam int HOLD = 100;
    logic clk = 0, rstn = 0, tool = 0, fact = 0, proj = 0, cs_rq = 0;
    logic cs_av = 0, kick_en = 1, subst = 0, slow = 0, done;
    logic su, rd, mn, wr, cs, er, rl, cr, inh, run, wde, led, ci;
    logic [1:0] sw = SW_RUN;
    logic [6:0] addr;
    logic [7:0] dimg, dsub, dout;
    logic [31:0] aimg, asub, aout;
    logic [3:0] kind = 4'h0;
    int n_fail = 0, cmp_count = 0, n_er = 0, k, seed = 32'hBFED;
    wire [6:0] ev = {ci, cr, cs, rl, er, wde, run};
    wire kick = kick_en & (mn | ~run);
    wire req = su | rd | mn | wr | er | rl | cr | cs;
    plcsup_top #(.WDOG_CNT(50), .HOLD_CNT(HOLD), .B1_HALF(5), .B2_HALF(3),
        .FL_HALF(2)) i_plcsup_top (.mclk_in(clk), .rstn_in(rstn),
        .mode_sw_in(sw), .tool_mres_req_in(tool), .factory_req_in(fact),
        .fw_name_match_in(1'b0), .project_present_in(proj),
        .cold_start_avail_in(cs_av), .cold_start_req_in(cs_rq),
        .wdog_kick_in(kick), .scan_limit_in(32'h3E8), .step_done_in(done),
        .dout_img_in(dimg), .aout_img_in(aimg), .aout_kind_in(kind),
        .subst_en_in(subst), .dout_subst_in(dsub), .aout_subst_in(asub),
        .clr_input_image_out(ci), .clr_output_image_out(),
        .read_input_image_out(rd), .write_output_image_out(wr),
        .startup_routine_out(su), .cyclic_main_program_out(mn),
        .cold_start_routine_out(cs), .erase_user_mem_out(er),
        .reload_project_out(rl), .clear_ram_out(cr), .fw_update_out(),
        .output_inhibit_out(inh), .run_out(run), .wdog_err_out(wde),
        .scan_err_out(), .yellow_led_out(led),
        .multipoint_station_address_out(addr), .dout_out(dout),
        .aout_out(aout));
    plcsup_engine_model i_plcsup_engine_model (.mclk_in(clk),
        .rstn_in(rstn), .req_in(req), .slow_in(slow), .done_out(done));
    function automatic logic [31:0] safe_aout(input logic [3:0] kd);
        safe_aout = {kd[3:2] == AKIND_I420 ? AOUT_4MA : AOUT_ZERO,
            kd[1:0] == AKIND_I420 ? AOUT_4MA : AOUT_ZERO};
    endfunction : safe_aout
    task report_and_stop;
        $display("compares %0d failures %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task chk(input logic [39:0] got, input logic [39:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // Bounded wait on one watched output; running out ends the run
    task wait_ev(input int b, input logic v, input int lim);
        for (int i = 0; i < lim && ev[b] !== v; i++) @(negedge clk);
        if (ev[b] !== v)
        begin
            n_fail++;
            report_and_stop();
        end
    endtask : wait_ev
    task led_chk;
        int n;
        n = 0;
        repeat (12) @(negedge clk) n += (led === 1'b1);
        chk(n, 12);
    endtask : led_chk
    initial forever #5 clk = ~clk;
    always @(negedge clk) slow <= ($random(seed) % 3) == 0;
    always @(negedge clk) n_er += (er === 1'b1);
    initial
    begin
        dimg = $random(seed);
        dsub = $random(seed);
        aimg = $random(seed);
        asub = $random(seed);
        cyc(16);
        rstn = 1;
        wait_ev(6, 1, 10);
        wait_ev(0, 1, 400);
        cyc(60);
        chk({dout, aout}, {dimg, aimg});
        sw = SW_STOP;
        wait_ev(0, 0, 60);
        cyc(2);
        chk(inh, 1);
        for (k = 0; k < 3; k++)
        begin
            kind = {2'(k), 2'((k + 1) % 3)};
            cyc(3);
            chk({dout, aout}, {8'h00, safe_aout(kind)});
        end
        subst = 1;
        cyc(3);
        chk({dout, aout}, {dsub, asub});
        subst = 0;
        sw = SW_MRES;
        cyc(HOLD / 2);
        sw = SW_STOP;
        cyc(150);
        chk(n_er, 0);
        proj = 1;
        sw = SW_MRES;
        cyc(HOLD + 20);
        led_chk();
        sw = SW_STOP;
        cyc(5);
        sw = SW_MRES;
        cyc(5);
        sw = SW_STOP;
        wait_ev(2, 1, 100);
        wait_ev(3, 1, 100);
        cyc(60);
        led_chk();
        chk(run, 0);
        proj = 0;
        sw = SW_RUN;
        wait_ev(0, 1, 400);
        tool = 1;
        wait_ev(2, 1, 60);
        tool = 0;
        chk(run, 0);
        sw = SW_STOP;
        cyc(5);
        sw = SW_RUN;
        wait_ev(0, 1, 400);
        kick_en = 0;
        wait_ev(1, 1, 300);
        kick_en = 1;
        sw = SW_STOP;
        cyc(5);
        sw = SW_RUN;
        cyc(60);
        chk(run, 0);
        cs_av = 1;
        cs_rq = 1;
        cyc(1);
        cs_rq = 0;
        wait_ev(0, 1, 400);
        sw = SW_STOP;
        wait_ev(0, 0, 100);
        fact = 1;
        cyc(1);
        fact = 0;
        wait_ev(5, 1, 60);
        cyc(3);
        chk(addr, 7'h02);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
